// File: cfg_pkg.sv
/*
 * constants, field layouts and carrier structs for the converter power and
 * clock configuration register bank.
 * assumes a single 250 MHz clock domain and an avalon-mm master outside.
 */
package cfg_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses are four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_LOW_SPEED = 8'h13;
	localparam logic [7:0] IDX_POWER = 8'h15;
	localparam logic [7:0] IDX_CLOCK_DIV = 8'h27;
	localparam logic [7:0] IDX_LINK_TEST = 8'h2A;
	localparam int ADDR_W = 10;
	// writable-bit masks: must-write-zero bits are held at zero
	localparam logic [7:0] MASK_LOW_SPEED = 8'h80;
	localparam logic [7:0] MASK_POWER = 8'hFD;
	localparam logic [7:0] MASK_CLOCK_DIV = 8'hC0;
	localparam logic [7:0] MASK_LINK_TEST = 8'hFF;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_LOW_SPEED = 7;
	localparam int BIT_CH_A = 7;
	localparam int BIT_STANDBY = 3;
	localparam int BIT_GLOBAL = 2;
	localparam int BIT_PIN_FUNC = 0;
	localparam int DIV_LSB = 6;
	localparam int TEST_LSB = 6;
	localparam int BIT_IDLE_SYNC = 5;
	localparam int BIT_SYNC_CODE = 4;
	localparam int BIT_FLIP = 3;
	localparam int BIT_LANE = 2;
	localparam int BIT_FRAME = 1;
	localparam int BIT_ILA_DIS = 0;
	localparam int NUM_CH = 4;
	localparam logic [1:0] SYNC_RESET = 2'h0;

	typedef enum logic [1:0] {
		DIV_BYPASS = 2'h0,
		DIV_BY_1 = 2'h1,
		DIV_BY_2 = 2'h2,
		DIV_BY_4 = 2'h3
	} clock_div_e;

	typedef enum logic [1:0] {
		TEST_NORMAL = 2'h0,
		TEST_CLOCK = 2'h1,
		TEST_ENCODED = 2'h2,
		TEST_PRBS15 = 2'h3
	} transport_test_e;

	// power controls seen by the analog core
	typedef struct packed {
		logic low_speed_mode;
		logic [3:0] channel_powerdown; // [3]=a .. [0]=d
		logic standby;
		logic whole_device_powerdown;
	} power_ctrl_s;

	// link test and alignment controls
	typedef struct packed {
		transport_test_e transport_test_select;
		logic idle_sync;
		logic sync_code_select;
		logic flip_data;
		logic lane_align;
		logic frame_align;
		logic initial_alignment_disable;
	} link_ctrl_s;
endpackage : cfg_pkg

// File: adc_power_clock_config_regs.sv
/*
 * avalon-mm register bank for converter power, clock divider and link test.
 * assumes the external power-down pin is asynchronous to clock.
 */
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ns
module adc_power_clock_config_regs (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [cfg_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic response_error,
	input wire logic external_powerdown_pin,
	output cfg_pkg::power_ctrl_s power_ctrl,
	output cfg_pkg::clock_div_e clock_div_select,
	output cfg_pkg::link_ctrl_s link_ctrl
);
	import cfg_pkg::*;

	logic [7:0] low_speed_q, power_q, clock_div_q, link_test_q;
	logic [2:0] pin_sync_q;
	logic pin_level_q;
	logic accept_q;
	logic [7:0] index;
	logic hit_low, hit_pwr, hit_div, hit_link, hit_any, wr_take;
	logic [7:0] rd_d;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// one wait state: waitrequest drops for one cycle after a request
	assign index = address[ADDR_W-1:2];
	assign hit_low = index == IDX_LOW_SPEED;
	assign hit_pwr = index == IDX_POWER;
	assign hit_div = index == IDX_CLOCK_DIV;
	assign hit_link = index == IDX_LINK_TEST;
	assign hit_any = hit_low | hit_pwr | hit_div | hit_link;
	assign wr_take = write & accept_q & byteenable[0];

	// request acceptance toggle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			accept_q <= 1'b0;
		end else begin
			accept_q <= (read | write) & ~accept_q;
		end
	end

	// waitrequest high unless the answer stands this cycle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= ~((read | write) & ~accept_q);
		end
	end

	// read mux
	always_comb begin
		rd_d = 8'h00;
		unique case (1'b1)
			hit_low: rd_d = low_speed_q;
			hit_pwr: rd_d = power_q;
			hit_div: rd_d = clock_div_q;
			hit_link: rd_d = link_test_q;
			default: rd_d = 8'h00;
		endcase
	end

	// read data and error answer, registered with the answer cycle
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			readdata <= 32'h0000_0000;
			response_error <= 1'b0;
		end else begin
			readdata <= {24'h00_0000, rd_d};
			response_error <= (read | write) & ~accept_q & ~hit_any;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// writes land only on the accept edge; must-write-zero bits stay zero
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			low_speed_q <= RESET_VALUE;
			power_q <= RESET_VALUE;
			clock_div_q <= RESET_VALUE;
			link_test_q <= RESET_VALUE;
		end else if (wr_take) begin
			if (hit_low) low_speed_q <= writedata[7:0] & MASK_LOW_SPEED;
			if (hit_pwr) power_q <= writedata[7:0] & MASK_POWER;
			if (hit_div) clock_div_q <= writedata[7:0] & MASK_CLOCK_DIV;
			if (hit_link) link_test_q <= writedata[7:0] & MASK_LINK_TEST;
		end
	end

	// ----------------------------------------------------------------
	// external pin synchroniser
	// ----------------------------------------------------------------
	// three stages; level changes when the second and third agree
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pin_sync_q <= 3'h0;
			pin_level_q <= 1'b0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], external_powerdown_pin};
			if (pin_sync_q[1] == pin_sync_q[2]) pin_level_q <= pin_sync_q[2];
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// power controls, pin merged by function select
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			power_ctrl <= '0;
		end else begin
			power_ctrl.low_speed_mode <= low_speed_q[BIT_LOW_SPEED];
			power_ctrl.channel_powerdown <= power_q[BIT_CH_A -: NUM_CH];
			power_ctrl.standby <= power_q[BIT_STANDBY]
				| (pin_level_q & power_q[BIT_PIN_FUNC]);
			power_ctrl.whole_device_powerdown <= power_q[BIT_GLOBAL]
				| (pin_level_q & ~power_q[BIT_PIN_FUNC]);
		end
	end

	// clock divider and link controls
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			clock_div_select <= DIV_BYPASS;
			link_ctrl <= '0;
		end else begin
			clock_div_select <= clock_div_e'(clock_div_q[DIV_LSB +: 2]);
			link_ctrl.transport_test_select <= transport_test_e'(link_test_q[TEST_LSB +: 2]);
			link_ctrl.idle_sync <= link_test_q[BIT_IDLE_SYNC];
			link_ctrl.sync_code_select <= link_test_q[BIT_SYNC_CODE];
			link_ctrl.flip_data <= link_test_q[BIT_FLIP];
			link_ctrl.lane_align <= link_test_q[BIT_LANE];
			link_ctrl.frame_align <= link_test_q[BIT_FRAME];
			link_ctrl.initial_alignment_disable <= link_test_q[BIT_ILA_DIS];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_CH_POWERDOWN: assert property (@(posedge clock) disable iff (sys_rst)
		power_ctrl.channel_powerdown == $past(power_q[7:4]))
		else $error("channel power-down does not follow register");
	AST_STANDBY_PIN: assert property (@(posedge clock) disable iff (sys_rst)
		($past(pin_level_q) && $past(power_q[0])) |-> power_ctrl.standby)
		else $error("pin did not force standby");
	AST_GLOBAL_PIN: assert property (@(posedge clock) disable iff (sys_rst)
		($past(pin_level_q) && !$past(power_q[0])) |-> power_ctrl.whole_device_powerdown)
		else $error("pin did not force global power-down");
	AST_STANDBY_OR: assert property (@(posedge clock) disable iff (sys_rst)
		(!$past(pin_level_q) && !$past(power_q[3])) |-> !power_ctrl.standby)
		else $error("standby without cause");
	AST_STANDBY_REG: assert property (@(posedge clock) disable iff (sys_rst)
		$past(power_q[3]) |-> power_ctrl.standby)
		else $error("standby bit ignored");
	AST_GLOBAL_REG: assert property (@(posedge clock) disable iff (sys_rst)
		$past(power_q[2]) |-> power_ctrl.whole_device_powerdown)
		else $error("global power-down bit ignored");
	AST_LOW_SPEED: assert property (@(posedge clock) disable iff (sys_rst)
		(write && accept_q && byteenable[0] && hit_low) |=> ##1
		power_ctrl.low_speed_mode == $past(writedata[7], 2))
		else $error("low-speed write not applied");
	AST_DIV: assert property (@(posedge clock) disable iff (sys_rst)
		clock_div_select == $past(clock_div_q[7:6]))
		else $error("divider select mismatch");
	AST_TEST_SEL: assert property (@(posedge clock) disable iff (sys_rst)
		link_ctrl.transport_test_select == $past(link_test_q[7:6]))
		else $error("transport test select mismatch");
	AST_ALIGN: assert property (@(posedge clock) disable iff (sys_rst)
		{link_ctrl.lane_align, link_ctrl.frame_align, link_ctrl.initial_alignment_disable}
		== $past(link_test_q[2:0]))
		else $error("alignment controls mismatch");
	AST_FRAME: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(link_test_q[1]) |=> link_ctrl.frame_align)
		else $error("frame align late");
	AST_ILA: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(link_test_q[0]) |=> !link_ctrl.initial_alignment_disable)
		else $error("alignment disable stuck");
	// write landing, must-write-zero bits, the far side of the pin merge, and lane align and alignment disable on a rise
	AST_LOW_MASK: assert property (@(posedge clock) disable iff (sys_rst)
		low_speed_q[6:0] == 7'h00)
		else $error("low-speed reserved bits set");
	AST_POWER_MASK: assert property (@(posedge clock) disable iff (sys_rst)
		power_q[1] == 1'b0)
		else $error("power reserved bit set");
	AST_DIV_MASK: assert property (@(posedge clock) disable iff (sys_rst)
		clock_div_q[5:0] == 6'h00)
		else $error("divider reserved bits set");
	AST_PWR_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_take && hit_pwr) |=> power_q == ($past(writedata[7:0]) & MASK_POWER))
		else $error("power write not applied");
	AST_DIV_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_take && hit_div) |=> clock_div_q == ($past(writedata[7:0]) & MASK_CLOCK_DIV))
		else $error("divider write not applied");
	AST_LINK_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
		(wr_take && hit_link) |=> link_test_q == ($past(writedata[7:0]) & MASK_LINK_TEST))
		else $error("link test write not applied");
	AST_GLOBAL_OR: assert property (@(posedge clock) disable iff (sys_rst)
		(!$past(pin_level_q) && !$past(power_q[2])) |-> !power_ctrl.whole_device_powerdown)
		else $error("global power-down without cause");
	AST_PIN_NOT_GLOBAL: assert property (@(posedge clock) disable iff (sys_rst)
		($past(power_q[0]) && !$past(power_q[2])) |-> !power_ctrl.whole_device_powerdown)
		else $error("standby pin caused global power-down");
	AST_PIN_NOT_STANDBY: assert property (@(posedge clock) disable iff (sys_rst)
		(!$past(power_q[0]) && !$past(power_q[3])) |-> !power_ctrl.standby)
		else $error("global pin caused standby");
	AST_LANE: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(link_test_q[2]) |=> link_ctrl.lane_align)
		else $error("lane align late");
	AST_ILA_SET: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(link_test_q[0]) |=> link_ctrl.initial_alignment_disable)
		else $error("alignment disable not applied");
endmodule : adc_power_clock_config_regs

// File: adc_power_clock_config_regs_tb.sv
/*
 * self-checking bench for the converter power, clock divider and link test register bank.
 * assumes cfg_pkg is compiled first and the design answers each avalon request after one wait state.
 */
`timescale 1ns/1ns
module adc_power_clock_config_regs_tb;
	import cfg_pkg::*;
	// ----------------------------------------------------------------
	// signals and table
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] wd;
		logic [7:0] rd;
		logic [16:0] outs;
	} row_s;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'h0;
	logic external_powerdown_pin = 1'b0;
	logic [31:0] readdata;
	logic waitrequest;
	logic response_error;
	power_ctrl_s power_ctrl;
	clock_div_e clock_div_select;
	link_ctrl_s link_ctrl;
	int err_count = 0;
	int compares = 0;
	logic [31:0] rdat;
	logic rerr;
	logic [7:0] regs [4] = '{8'h13, 8'h15, 8'h27, 8'h2A};
	// rows: index, write value, read-back, {power_ctrl, clock_div_select, link_ctrl}
	row_s rows [14] = '{
		'{8'h13, 8'hFF, 8'h80, 17'h10000}, '{8'h13, 8'h00, 8'h00, 17'h00000},
		'{8'h15, 8'hA0, 8'hA0, 17'h0A000}, '{8'h15, 8'h58, 8'h58, 17'h05800},
		'{8'h15, 8'h06, 8'h04, 17'h00400}, '{8'h15, 8'h01, 8'h01, 17'h00000},
		'{8'h27, 8'h00, 8'h00, 17'h00000}, '{8'h27, 8'h40, 8'h40, 17'h00100},
		'{8'h27, 8'h80, 8'h80, 17'h00200}, '{8'h27, 8'hFF, 8'hC0, 17'h00300},
		'{8'h2A, 8'h44, 8'h44, 17'h00344}, '{8'h2A, 8'h82, 8'h82, 17'h00382},
		'{8'h2A, 8'hC1, 8'hC1, 17'h003C1}, '{8'h2A, 8'h38, 8'h38, 17'h00338}};

	// 250 MHz clock
	always #2 clock = ~clock;

	adc_power_clock_config_regs DUT (.clock(clock), .sys_rst(sys_rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .response_error(response_error),
		.external_powerdown_pin(external_powerdown_pin), .power_ctrl(power_ctrl),
		.clock_div_select(clock_div_select), .link_ctrl(link_ctrl));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		if (err_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one avalon transfer: hold until waitrequest is sampled low, then release
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		input logic [3:0] be, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		address <= {idx, 2'b00};
		writedata <= {24'h0, wd};
		byteenable <= be;
		write <= wr;
		read <= ~wr;
		@(posedge clock);
		while (waitrequest !== 1'b0) begin
			n++;
			if (n > 20) begin
				err_count++;
				$display("MISMATCH %0t bus timeout", $time);
				final_report();
			end
			@(posedge clock);
		end
		rd = readdata;
		er = response_error;
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clock);
	endtask : bus

	task automatic pwr(input logic [7:0] v, input logic pin, input logic [6:0] exp);
		bus(1'b1, 8'h15, v, 4'h1, rdat, rerr);
		external_powerdown_pin <= pin;
		repeat (8) @(posedge clock);
		check({25'h0, power_ctrl}, {25'h0, exp});
	endtask : pwr

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		// reset values
		check({15'h0, power_ctrl, clock_div_select, link_ctrl}, 32'h0);
		foreach (regs[i]) begin
			bus(1'b0, regs[i], 8'h00, 4'h1, rdat, rerr);
			check(rdat, 32'h0);
		end
		// table of writes, read-backs and control outputs
		for (int i = 0; i < 14; i++) begin
			bus(1'b1, rows[i].idx, rows[i].wd, 4'h1, rdat, rerr);
			bus(1'b0, rows[i].idx, 8'h00, 4'h1, rdat, rerr);
			check(rdat, {24'h0, rows[i].rd});
			check({31'h0, rerr}, 32'h0);
			check({15'h0, power_ctrl, clock_div_select, link_ctrl}, {15'h0, rows[i].outs});
		end
		// pin meaning under the function select, ored with the register bits
		pwr(8'h01, 1'b1, 7'h02);
		pwr(8'h00, 1'b1, 7'h01);
		pwr(8'h08, 1'b1, 7'h03);
		pwr(8'h09, 1'b0, 7'h02);
		pwr(8'h04, 1'b1, 7'h01);
		// unmapped index answers with an error and reads zero
		bus(1'b1, 8'h14, 8'hFF, 4'h1, rdat, rerr);
		bus(1'b0, 8'h14, 8'h00, 4'h1, rdat, rerr);
		check(rdat, 32'h0);
		check({31'h0, rerr}, 32'h1);
		// write without the low byte lane leaves the register alone
		bus(1'b1, 8'h27, 8'h00, 4'hE, rdat, rerr);
		bus(1'b0, 8'h27, 8'h00, 4'h1, rdat, rerr);
		check(rdat, 32'hC0);
		// second reset in mid-run clears the registers and outputs and raises waitrequest
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		check({14'h0, waitrequest, power_ctrl, clock_div_select, link_ctrl}, 32'h20000);
		sys_rst <= 1'b0;
		@(posedge clock);
		bus(1'b0, 8'h2A, 8'h00, 4'h1, rdat, rerr);
		check(rdat, 32'h0);
		final_report();
	end
endmodule : adc_power_clock_config_regs_tb
